// ==== hdl/pcm_pkg.sv ====
// Constants, register map and types for the PCM highway serial port
package pcm_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int STBY_US = 250;
  localparam int STBY_CYC = STBY_US * CLK_MHZ;
  localparam int BLANK_US = 500;
  localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
  localparam int CLK_STOP_US = 20;
  localparam int CLK_STOP_CYC = CLK_STOP_US * CLK_MHZ;
  localparam int VAR_IDLE_US = 20;
  localparam int VAR_IDLE_CYC = VAR_IDLE_US * CLK_MHZ;
  // ---------------------------------------------------------------
  // Word and frame format
  // ---------------------------------------------------------------
  localparam int WORD_W = 8;
  localparam logic [2:0] IDX_LAST = 3'h7;
  localparam logic [1:0] SIG_WIDTH = 2'h2;
  localparam logic [1:0] FS_CNT_MAX = 2'h3;
  // ---------------------------------------------------------------
  // Pin vector positions
  // ---------------------------------------------------------------
  localparam int N_IN = 11;
  localparam int IN_TXM = 0;
  localparam int IN_RXM = 1;
  localparam int IN_TXB = 2;
  localparam int IN_RXB = 3;
  localparam int IN_TXFS = 4;
  localparam int IN_RXFS = 5;
  localparam int IN_PCM = 6;
  localparam int IN_PDN = 7;
  localparam int IN_SIG = 8;
  localparam int IN_FSEL = 9;
  localparam int IN_LOOP = 10;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] TX_WORD_OFS = 8'h00;
  localparam logic [7:0] RX_WORD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] TX_WORD_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam int ST_VAR = 0;
  localparam int ST_TXSTBY = 1;
  localparam int ST_RXSTBY = 2;
  localparam int ST_PD = 3;
  localparam int ST_RXSIG = 4;
  localparam int ST_FSEL = 5;
  localparam int ST_LOOP = 6;
  localparam int ST_RXNEW = 7;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACT = 1;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } pcm_tx_state_e;
endpackage : pcm_pkg

// ==== hdl/pcm_sync_edge.sv ====
// Two-flop synchroniser with edge detection for a vector of pins
`timescale 1ns/1ns
`default_nettype none
module pcm_sync_edge #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign lvl = s2_reg;
  assign rise = s2_reg & ~s3_reg;
  assign fall = ~s2_reg & s3_reg;
endmodule : pcm_sync_edge
`default_nettype wire

// ==== hdl/pcm_tdm_port.sv ====
// PCM highway serial port with AHB-Lite status and word registers
//
// Behaviour
// - Power-down low floats data and strobe, forces rx signalling low quickly.
// - Both frame syncs idle: float data and strobe, rx signalling low.
// - Tx frame sync idle alone: data and strobe go high impedance.
// - Rx frame sync idle alone: rx signalling output goes high impedance.
// - First strobe after power-up or standby may be shorter than eight bits.
// - Sync one master clock wide is normal, two wide is signalling.
// - Fixed rate: send word on first eight tx master rising edges.
// - Fixed rate: sample input on first eight rx master falling edges.
// - Variable rate: while tx slot enabled, send on eight bit-clock rises.
// - Variable rate: while rx slot enabled, capture on eight bit-clock falls.
// - Variable rate: repeat the same word while slot enable and clock continue.
// - Signalling frames exist only in fixed-rate mode.
// - Tx signalling frame replaces outgoing LSB by the signalling input.
// - Rx signalling frame: keep seven upper bits, hold LSB on signalling out.
// - Tx and rx signalling frames are detected independently.
// - Loopback input high routes receive analog output back into transmit.
// - Words travel MSB (sign) first, LSB last.
// - After power-up, data and strobe stay floating about four frames.
// - Stopped tx master clock floats outputs; stopped rx clock holds signalling low.
// - Strobe low from first bit of the slot until after eighth bit.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module pcm_tdm_port #(
  parameter int STBY_CYC = pcm_pkg::STBY_CYC,
  parameter int BLANK_CYC = pcm_pkg::BLANK_CYC,
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [pcm_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tx_master_clock,
  input wire logic rx_master_clock,
  input wire logic tx_bit_clock,
  input wire logic rx_bit_clock,
  input wire logic tx_frame_sync,
  input wire logic rx_frame_sync,
  input wire logic pcm_data_in,
  input wire logic power_down_n,
  input wire logic tx_signalling_in,
  input wire logic master_freq_select,
  input wire logic loopback_control,
  output logic pcm_data_out,
  output logic pcm_data_oe,
  output logic tx_slot_strobe_n,
  output logic tx_slot_strobe_oe,
  output logic rx_signalling_out,
  output logic rx_signalling_oe,
  output logic analog_loop_en
);
  // ---------------------------------------------------------------
  // Parameter checks and limits
  // ---------------------------------------------------------------
  if (CNT_W < 13 || STBY_CYC < 1 || BLANK_CYC < 1 || STBY_CYC >= 2**CNT_W ||
      BLANK_CYC >= 2**CNT_W) begin : g_bad_param
    $error("pcm_tdm_port: counter width too small for the timing counts");
  end

  localparam logic [CNT_W-1:0] STBY_LIM = CNT_W'(STBY_CYC);
  localparam logic [CNT_W-1:0] BLANK_LIM = CNT_W'(BLANK_CYC);
  localparam logic [CNT_W-1:0] STOP_LIM = CNT_W'(pcm_pkg::CLK_STOP_CYC);
  localparam logic [CNT_W-1:0] VAR_LIM = CNT_W'(pcm_pkg::VAR_IDLE_CYC);

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c,
                                               input logic [CNT_W-1:0] lim);
    sat_inc = (c >= lim) ? c : c + 1'b1;
  endfunction : sat_inc

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [pcm_pkg::N_IN-1:0] pin_raw;
  logic [pcm_pkg::N_IN-1:0] pin_lvl;
  logic [pcm_pkg::N_IN-1:0] pin_rise;
  logic [pcm_pkg::N_IN-1:0] pin_fall;

  assign pin_raw = {loopback_control, master_freq_select, tx_signalling_in, power_down_n,
                    pcm_data_in, rx_frame_sync, tx_frame_sync, rx_bit_clock, tx_bit_clock,
                    rx_master_clock, tx_master_clock};

  pcm_sync_edge #(.W(pcm_pkg::N_IN)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .din(pin_raw),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  logic pd;
  logic tx_fs_lvl;
  logic rx_fs_lvl;
  logic pcm_in_lvl;
  assign pd = !pin_lvl[pcm_pkg::IN_PDN];
  assign tx_fs_lvl = pin_lvl[pcm_pkg::IN_TXFS];
  assign rx_fs_lvl = pin_lvl[pcm_pkg::IN_RXFS];
  assign pcm_in_lvl = pin_lvl[pcm_pkg::IN_PCM];

  // ---------------------------------------------------------------
  // Mode, standby, blanking and clock-loss timers
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] var_idle_reg;
  logic [CNT_W-1:0] tx_dead_reg;
  logic [CNT_W-1:0] rx_dead_reg;
  logic [CNT_W-1:0] tx_idle_reg;
  logic [CNT_W-1:0] rx_idle_reg;
  logic [CNT_W-1:0] blank_reg;
  logic var_mode;
  logic tx_dead;
  logic rx_dead;
  logic tx_stby;
  logic rx_stby;
  logic blank;
  logic tx_live;
  logic rx_live;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      var_idle_reg <= VAR_LIM;
      tx_dead_reg <= '0;
      rx_dead_reg <= '0;
      tx_idle_reg <= '0;
      rx_idle_reg <= '0;
      blank_reg <= BLANK_LIM;
    end else begin
      var_idle_reg <= (pin_rise[pcm_pkg::IN_RXB] || pin_fall[pcm_pkg::IN_RXB]) ? '0 :
                      sat_inc(var_idle_reg, VAR_LIM);
      tx_dead_reg <= (pin_rise[pcm_pkg::IN_TXM] || pin_fall[pcm_pkg::IN_TXM]) ? '0 :
                     sat_inc(tx_dead_reg, STOP_LIM);
      rx_dead_reg <= (pin_rise[pcm_pkg::IN_RXM] || pin_fall[pcm_pkg::IN_RXM]) ? '0 :
                     sat_inc(rx_dead_reg, STOP_LIM);
      tx_idle_reg <= tx_fs_lvl ? '0 : sat_inc(tx_idle_reg, STBY_LIM);
      rx_idle_reg <= rx_fs_lvl ? '0 : sat_inc(rx_idle_reg, STBY_LIM);
      if (pd) begin
        blank_reg <= BLANK_LIM;
      end else if (blank_reg != '0) begin
        blank_reg <= blank_reg - 1'b1;
      end
    end
  end

  assign var_mode = var_idle_reg < VAR_LIM;
  assign tx_dead = tx_dead_reg >= STOP_LIM;
  assign rx_dead = rx_dead_reg >= STOP_LIM;
  assign tx_stby = tx_idle_reg >= STBY_LIM;
  assign rx_stby = rx_idle_reg >= STBY_LIM;
  assign blank = blank_reg != '0;
  assign tx_live = !pd && !tx_stby && !blank && !tx_dead;
  assign rx_live = !pd && !rx_stby && !blank && !rx_dead;

  // ---------------------------------------------------------------
  // Frame type decoding
  // ---------------------------------------------------------------
  logic [1:0] tx_fs_cnt_reg;
  logic [1:0] rx_fs_cnt_reg;
  logic tx_sig_frame;
  logic rx_sig_frame;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_fs_cnt_reg <= '0;
      rx_fs_cnt_reg <= '0;
    end else begin
      if (pin_rise[pcm_pkg::IN_TXFS]) begin
        tx_fs_cnt_reg <= '0;
      end else if (tx_fs_lvl && pin_rise[pcm_pkg::IN_TXM] &&
                   tx_fs_cnt_reg != pcm_pkg::FS_CNT_MAX) begin
        tx_fs_cnt_reg <= tx_fs_cnt_reg + 1'b1;
      end
      if (pin_rise[pcm_pkg::IN_RXFS]) begin
        rx_fs_cnt_reg <= '0;
      end else if (rx_fs_lvl && pin_rise[pcm_pkg::IN_RXM] &&
                   rx_fs_cnt_reg != pcm_pkg::FS_CNT_MAX) begin
        rx_fs_cnt_reg <= rx_fs_cnt_reg + 1'b1;
      end
    end
  end

  assign tx_sig_frame = !var_mode && tx_fs_cnt_reg == pcm_pkg::SIG_WIDTH;
  assign rx_sig_frame = !var_mode && rx_fs_cnt_reg == pcm_pkg::SIG_WIDTH;

  // ---------------------------------------------------------------
  // Transmit shifter
  // ---------------------------------------------------------------
  pcm_pkg::pcm_tx_state_e tx_state_reg;
  pcm_pkg::pcm_tx_state_e tx_state_next;
  logic [2:0] tx_idx_reg;
  logic [2:0] tx_idx_next;
  logic [pcm_pkg::WORD_W-1:0] tx_lat_reg;
  logic [pcm_pkg::WORD_W-1:0] tx_lat_next;
  logic [pcm_pkg::WORD_W-1:0] tx_word_reg;
  logic tx_arm_reg;
  logic tx_arm_next;
  logic tx_clk_rise;
  logic tx_clk_fall;
  logic tx_shifting;
  logic tx_last;
  logic tx_fire;
  logic tx_stop;
  logic tx_bit_next;
  logic tx_drive;
  logic pcm_data_reg;
  logic pcm_data_oe_reg;
  logic tx_strobe_n_reg;
  logic tx_strobe_oe_reg;

  assign tx_clk_rise = var_mode ? pin_rise[pcm_pkg::IN_TXB] : pin_rise[pcm_pkg::IN_TXM];
  assign tx_clk_fall = var_mode ? pin_fall[pcm_pkg::IN_TXB] : pin_fall[pcm_pkg::IN_TXM];
  assign tx_shifting = tx_state_reg == pcm_pkg::TX_SHIFT;
  assign tx_last = tx_idx_reg == pcm_pkg::IDX_LAST;
  assign tx_fire = tx_live && tx_clk_rise &&
                   (var_mode ? tx_fs_lvl : (tx_arm_reg || tx_shifting));
  assign tx_stop = !tx_live || (var_mode ? !tx_fs_lvl : (tx_clk_fall && tx_last));

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_idx_next = tx_idx_reg;
    tx_lat_next = tx_lat_reg;
    tx_arm_next = tx_arm_reg;
    if (pin_rise[pcm_pkg::IN_TXFS] && !var_mode) begin
      tx_arm_next = 1'b1;
    end
    case (tx_state_reg)
      pcm_pkg::TX_IDLE: begin
        if (tx_fire) begin
          tx_state_next = pcm_pkg::TX_SHIFT;
          tx_idx_next = '0;
          tx_lat_next = tx_word_reg;
          tx_arm_next = 1'b0;
        end
      end
      pcm_pkg::TX_SHIFT: begin
        if (tx_stop) begin
          tx_state_next = pcm_pkg::TX_IDLE;
        end else if (tx_fire) begin
          tx_idx_next = tx_idx_reg + 1'b1;
          if (tx_last) begin
            tx_lat_next = tx_word_reg;
          end
        end
      end
      default: begin
        tx_state_next = pcm_pkg::TX_IDLE;
      end
    endcase
  end

  assign tx_bit_next = (tx_sig_frame && tx_idx_next == pcm_pkg::IDX_LAST) ?
                       pin_lvl[pcm_pkg::IN_SIG] :
                       tx_lat_next[pcm_pkg::IDX_LAST - tx_idx_next];
  assign tx_drive = tx_live && tx_state_next == pcm_pkg::TX_SHIFT;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_state_reg <= pcm_pkg::TX_IDLE;
      tx_idx_reg <= '0;
      tx_lat_reg <= '0;
      tx_arm_reg <= 1'b0;
      pcm_data_reg <= 1'b0;
      pcm_data_oe_reg <= 1'b0;
      tx_strobe_n_reg <= 1'b1;
      tx_strobe_oe_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_idx_reg <= tx_idx_next;
      tx_lat_reg <= tx_lat_next;
      tx_arm_reg <= tx_arm_next;
      if (tx_fire) begin
        pcm_data_reg <= tx_bit_next;
      end
      pcm_data_oe_reg <= tx_drive;
      tx_strobe_n_reg <= !tx_drive;
      tx_strobe_oe_reg <= tx_live;
    end
  end

  // ---------------------------------------------------------------
  // Receive shifter and signalling output
  // ---------------------------------------------------------------
  logic [2:0] rx_idx_reg;
  logic [pcm_pkg::WORD_W-1:0] rx_shift_reg;
  logic [pcm_pkg::WORD_W-1:0] rx_word_reg;
  logic rx_arm_reg;
  logic rx_clk_fall;
  logic rx_fire;
  logic rx_done;
  logic rx_sig_low;
  logic rx_hiz;
  logic rx_sig_val_reg;
  logic rx_sig_out_reg;
  logic rx_sig_oe_reg;
  logic rx_new_reg;

  assign rx_clk_fall = var_mode ? pin_fall[pcm_pkg::IN_RXB] : pin_fall[pcm_pkg::IN_RXM];
  assign rx_fire = rx_live && rx_arm_reg && rx_clk_fall &&
                   (!var_mode || rx_fs_lvl);
  assign rx_done = rx_fire && rx_idx_reg == pcm_pkg::IDX_LAST;
  assign rx_sig_low = pd || (tx_stby && rx_stby) || rx_dead || blank;
  assign rx_hiz = !pd && rx_stby && !tx_stby;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_idx_reg <= '0;
      rx_shift_reg <= '0;
      rx_word_reg <= '0;
      rx_arm_reg <= 1'b0;
    end else begin
      if (!rx_live || (var_mode && !rx_fs_lvl)) begin
        rx_arm_reg <= 1'b0;
      end else if (pin_rise[pcm_pkg::IN_RXFS]) begin
        rx_arm_reg <= 1'b1;
      end else if (rx_done) begin
        rx_arm_reg <= 1'b0;
      end
      if (pin_rise[pcm_pkg::IN_RXFS]) begin
        rx_idx_reg <= '0;
      end else if (rx_fire) begin
        rx_idx_reg <= rx_idx_reg + 1'b1;
      end
      if (rx_fire) begin
        rx_shift_reg <= {rx_shift_reg[pcm_pkg::WORD_W-2:0], pcm_in_lvl};
      end
      if (rx_done) begin
        rx_word_reg <= {rx_shift_reg[pcm_pkg::WORD_W-2:0],
                        pcm_in_lvl && !rx_sig_frame};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_sig_val_reg <= 1'b0;
      rx_sig_out_reg <= 1'b0;
      rx_sig_oe_reg <= 1'b1;
    end else begin
      if (rx_sig_low) begin
        rx_sig_val_reg <= 1'b0;
      end else if (rx_done && rx_sig_frame) begin
        rx_sig_val_reg <= pcm_in_lvl;
      end
      rx_sig_out_reg <= rx_sig_low ? 1'b0 : rx_sig_val_reg;
      rx_sig_oe_reg <= !rx_hiz;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  logic ahb_go;
  logic rd_go;
  logic wr_pend_reg;
  logic [pcm_pkg::ADDR_W-1:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_data;
  logic [7:0] status_word;
  logic hreadyout_reg;
  logic hresp_reg;
  logic loop_reg;

  assign ahb_go = hsel && hready && htrans[pcm_pkg::HTRANS_ACT];
  assign rd_go = ahb_go && !hwrite;
  assign status_word[pcm_pkg::ST_VAR] = var_mode;
  assign status_word[pcm_pkg::ST_TXSTBY] = tx_stby;
  assign status_word[pcm_pkg::ST_RXSTBY] = rx_stby;
  assign status_word[pcm_pkg::ST_PD] = pd;
  assign status_word[pcm_pkg::ST_RXSIG] = rx_sig_val_reg;
  assign status_word[pcm_pkg::ST_FSEL] = pin_lvl[pcm_pkg::IN_FSEL];
  assign status_word[pcm_pkg::ST_LOOP] = loop_reg;
  assign status_word[pcm_pkg::ST_RXNEW] = rx_new_reg;
  assign rd_data = (haddr == pcm_pkg::TX_WORD_OFS) ? {24'h00_0000, tx_word_reg} :
                   (haddr == pcm_pkg::RX_WORD_OFS) ? {24'h00_0000, rx_word_reg} :
                   (haddr == pcm_pkg::STATUS_OFS) ? {24'h00_0000, status_word} :
                   pcm_pkg::RDATA_RST;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_reg <= pcm_pkg::RDATA_RST;
      tx_word_reg <= pcm_pkg::TX_WORD_RST;
      rx_new_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      loop_reg <= 1'b0;
    end else begin
      wr_pend_reg <= ahb_go && hwrite && hsize == pcm_pkg::HSIZE_WORD;
      wr_addr_reg <= haddr;
      if (rd_go) begin
        hrdata_reg <= rd_data;
      end
      if (wr_pend_reg && wr_addr_reg == pcm_pkg::TX_WORD_OFS) begin
        tx_word_reg <= hwdata[pcm_pkg::WORD_W-1:0];
      end
      if (rx_done) begin
        rx_new_reg <= 1'b1;
      end else if (rd_go && haddr == pcm_pkg::RX_WORD_OFS) begin
        rx_new_reg <= 1'b0;
      end
      loop_reg <= pin_lvl[pcm_pkg::IN_LOOP];
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign pcm_data_out = pcm_data_reg;
  assign pcm_data_oe = pcm_data_oe_reg;
  assign tx_slot_strobe_n = tx_strobe_n_reg;
  assign tx_slot_strobe_oe = tx_strobe_oe_reg;
  assign rx_signalling_out = rx_sig_out_reg;
  assign rx_signalling_oe = rx_sig_oe_reg;
  assign analog_loop_en = loop_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_pd_outputs: assert property (pd |=> !pcm_data_oe && !tx_slot_strobe_oe &&
      rx_signalling_oe && !rx_signalling_out)
    else $error("power-down outputs wrong");
  a_full_standby: assert property (tx_stby && rx_stby |=> !pcm_data_oe &&
      !tx_slot_strobe_oe && !rx_signalling_out)
    else $error("full standby outputs wrong");
  a_tx_standby: assert property (tx_stby |=> !pcm_data_oe && !tx_slot_strobe_oe)
    else $error("tx standby not floating");
  a_rx_standby: assert property (rx_hiz |=> !rx_signalling_oe)
    else $error("rx standby signalling driven");
  a_sig_lsb_insert: assert property (tx_fire && tx_shifting && !tx_stop && tx_sig_frame &&
      tx_idx_reg == 3'h6 |=> pcm_data_out == $past(pin_lvl[pcm_pkg::IN_SIG]))
    else $error("signalling bit not inserted");
  a_rx_sig_take: assert property (rx_done && rx_sig_frame && !rx_sig_low |=>
      rx_sig_val_reg == $past(pcm_in_lvl) ##1 rx_signalling_out == rx_sig_val_reg
      || rx_sig_low)
    else $error("rx signalling bit not taken");
  a_rx_sig_hold: assert property (!(rx_done && rx_sig_frame) && !rx_sig_low |=>
      $stable(rx_sig_val_reg))
    else $error("rx signalling changed outside signalling frame");
  a_var_no_sig: assert property (var_mode && rx_done |=>
      rx_word_reg[0] == $past(pcm_in_lvl))
    else $error("signalling frame in variable mode");
  a_strobe_data: assert property (!tx_slot_strobe_n |-> pcm_data_oe && tx_slot_strobe_oe)
    else $error("strobe low without data");
  a_blank_float: assert property (blank |=> !pcm_data_oe)
    else $error("data driven during start-up blanking");
  a_clk_stop: assert property (tx_dead |=> !pcm_data_oe ##0 !tx_slot_strobe_oe)
    else $error("outputs driven with tx clock stopped");
  a_fixed_eight: assert property (!var_mode && tx_fire && tx_shifting && !tx_stop |->
      !tx_last)
    else $error("more than eight bits in fixed slot");
  a_var_repeat: assert property (var_mode && tx_fire && tx_shifting && tx_last && !tx_stop
      |=> tx_idx_reg == 3'h0 && tx_shifting)
    else $error("variable-rate word not repeated");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not ready OKAY");
endmodule : pcm_tdm_port
`default_nettype wire

// ==== testbench/pcm_hwy_model.sv ====
// Behavioural highway controller making fixed-rate frames, or sixteen-clock variable-rate frames when wide
`timescale 1ns/1ns
`default_nettype none
module pcm_hwy_model (
  input wire logic go,
  input wire logic sig,
  input wire logic wide,
  input wire logic [7:0] rx_word,
  input wire logic pcm_data_out,
  output logic mclk,
  output logic fs,
  output logic pdin,
  output logic [7:0] tx_cap,
  output logic [7:0] nfr
);
  initial begin
    {mclk, fs, pdin, tx_cap, nfr} = '0;
  end
  always #40 mclk = ~mclk;
  always @(posedge mclk) begin
    if (go) begin
      #20 fs = 1'b1;
      pdin = rx_word[7];
      for (int k = 1; k <= (wide ? 16 : 8); k++) begin
        @(posedge mclk);
        if (k < 8) pdin = rx_word[7-k];
        #20 if (!wide && k == (sig ? 2 : 1)) fs = 1'b0;
        #40 tx_cap[7-((k-1)%8)] = pcm_data_out;
      end
      fs = 1'b0;
      pdin = ~pdin;
      nfr = nfr + 8'h01;
      repeat (2) @(posedge mclk);
    end
  end
endmodule : pcm_hwy_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the highway serial port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, go = 0, sig = 0, sigin = 0, pdn_n = 1, lp = 0;
  logic [7:0] haddr = 8'h00, rxw = 8'h00, cap, nfr;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
  logic hrdy, mclk, fs, pdin, pdo, pdoe, stb_oe, sigo, aloop, hrsp, stb_n, sig_oe;
  logic vm = 0, fsel = 1;
  logic [2:0] hsz = 3'h2;
  int fails = 0, samples_checked = 0;
  always #5 clk = ~clk;
  pcm_tdm_port #(.STBY_CYC(200), .BLANK_CYC(100)) DUT (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsz), .hwdata(hwdata),
    .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hrsp), .tx_master_clock(mclk),
    .rx_master_clock(mclk), .tx_bit_clock(vm & mclk), .rx_bit_clock(vm & mclk),
    .tx_frame_sync(fs),
    .rx_frame_sync(fs), .pcm_data_in(pdin), .power_down_n(pdn_n), .tx_signalling_in(sigin),
    .master_freq_select(fsel), .loopback_control(lp), .pcm_data_out(pdo), .pcm_data_oe(pdoe),
    .tx_slot_strobe_n(stb_n), .tx_slot_strobe_oe(stb_oe), .rx_signalling_out(sigo),
    .rx_signalling_oe(sig_oe), .analog_loop_en(aloop));
  pcm_hwy_model HWY (.go(go), .sig(sig), .wide(vm), .rx_word(rxw),
    .pcm_data_out((pdoe && stb_oe && !stb_n) ? pdo : 1'bx), .mclk(mclk),
    .fs(fs), .pdin(pdin), .tx_cap(cap), .nfr(nfr));
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, a};
    do @(posedge clk); while (hrdy !== 1'b1 && ++n < 99);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge clk); while (hrdy !== 1'b1 && ++n < 99);
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hrsp});
    if (n >= 99) begin
      fails++;
      final_report();
    end
  endtask : xfer
  task automatic frames(input int k);
    logic [7:0] s;
    int n;
    s = nfr;
    for (n = 0; nfr !== 8'(s + k) && n < 5000; n++) @(posedge clk);
    if (n >= 5000) begin
      fails++;
      final_report();
    end
  endtask : frames
  initial begin
    repeat (5) @(posedge clk);
    {nrst, go, rxw} <= {2'b11, 8'hA5};
    xfer(8'h00, 1'b1, 32'h0000_003C);
    frames(3);
    chk("tx", 32'h0000_003C, {24'h0, cap});
    hsz <= 3'h0;
    xfer(8'h00, 1'b1, 32'h0000_00FF);
    hsz <= 3'h2;
    xfer(8'h00, 1'b0, 32'h0000_0000);
    chk("size", 32'h0000_003C, rd);
    xfer(8'h04, 1'b0, 32'h0000_0000);
    chk("rx", 32'h0000_00A5, rd);
    {sig, sigin, rxw} <= {2'b11, 8'h5B};
    frames(3);
    chk("tx_sig", 32'h0000_003D, {24'h0, cap});
    xfer(8'h04, 1'b0, 32'h0000_0000);
    chk("rx_sig", 32'h0000_005A, rd);
    chk("sig_out", 32'h0000_0001, {31'h0, sigo});
    {sig, rxw} <= {1'b0, 8'h00};
    frames(3);
    chk("sig_hold", 32'h0000_0001, {31'h0, sigo});
    chk("tx_norm", 32'h0000_003C, {24'h0, cap});
    {vm, rxw} <= {1'b1, 8'h5B};
    frames(3);
    chk("var_tx", 32'h0000_003C, {24'h0, cap});
    xfer(8'h04, 1'b0, 32'h0000_0000);
    chk("var_rx", 32'h0000_005B, rd);
    vm <= 1'b0;
    lp <= 1'b1;
    repeat (8) @(posedge clk);
    chk("loop", 32'h0000_0001, {31'h0, aloop});
    xfer(8'h08, 1'b0, 32'h0000_0000);
    chk("status", 32'h0000_0060, rd & 32'h0000_0060);
    pdn_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("pd", 32'h0000_0001, {28'h0, pdoe, stb_oe, sigo, sig_oe});
    {pdn_n, go} <= 2'b10;
    repeat (300) @(posedge clk);
    chk("stby", 32'h0000_0001, {28'h0, pdoe, stb_oe, sigo, sig_oe});
    final_report();
  end
endmodule : tb_top
`default_nettype wire
